// ---- fbos_map.vh ----
/*
 * Constants for the per-bank output state selector: command codes,
 * output state encodings, bank count and width, and status error bits.
 * Assumes it is included by bare name and that the command decoder
 * upstream presents one already-classified command per strobe.
 */
`ifndef FBOS_MAP_VH
`define FBOS_MAP_VH

`define FBOS_NBANKS        8
`define FBOS_BANK_W        3

// Output states
`define FBOS_OUT_W         2
`define FBOS_OUT_ARRAY     2'h0
`define FBOS_OUT_STATUS    2'h1
`define FBOS_OUT_SIG       2'h2
`define FBOS_OUT_QUERY     2'h3

// Classified command codes
`define FBOS_CMD_W         4
`define FBOS_CMD_RD_ARRAY  4'h0
`define FBOS_CMD_PROG_SU   4'h1
`define FBOS_CMD_ERASE_SU  4'h2
`define FBOS_CMD_FP_SU     4'h3
`define FBOS_CMD_QFP_SU    4'h4
`define FBOS_CMD_CONFIRM   4'h5
`define FBOS_CMD_SUSPEND   4'h6
`define FBOS_CMD_RD_STATUS 4'h7
`define FBOS_CMD_CLR_STAT  4'h8
`define FBOS_CMD_RD_SIG    4'h9
`define FBOS_CMD_RD_QUERY  4'hA
`define FBOS_CMD_OTHER     4'hF

// Status register error bits
`define FBOS_ERR_W         5
`define FBOS_ERR_RESET     5'h00

`endif

// ---- fbos_bank_state.v ----
/*
 * One bank's output state holder.
 * Assumes load and value arrive on the same clock as clk.
 */
`include "fbos_map.vh"
module fbos_bank_state (
	input  wire                   clk,
	input  wire                   rst_n,
	input  wire                   load,
	input  wire [`FBOS_OUT_W-1:0] value,
	output reg  [`FBOS_OUT_W-1:0] state_q
);
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= `FBOS_OUT_ARRAY;
		end else if (load) begin
			state_q <= value;
		end
	end
endmodule // fbos_bank_state

// ---- fbos_select.v ----
/*
 * Per-bank output state selection for a multi-bank flash command
 * interface. Takes classified command strobes with a bank address,
 * the program/erase controller's busy and suspend levels (from pins,
 * so synchronised here), and drives each bank's output state, a
 * data-path selector for a read bank, and the status error bits.
 * Assumes command strobes come from logic on clk.
 */
`include "fbos_map.vh"
module fbos_select (
	input  wire                                 clk,
	input  wire                                 rst_n,
	input  wire                                 cmd_valid,
	input  wire [`FBOS_CMD_W-1:0]               cmd_code,
	input  wire [`FBOS_BANK_W-1:0]              cmd_bank,
	input  wire                                 pe_busy,
	input  wire                                 pe_suspended,
	input  wire                                 err_set,
	input  wire [`FBOS_ERR_W-1:0]               err_in,
	input  wire [`FBOS_BANK_W-1:0]              rd_bank,
	output reg  [`FBOS_NBANKS*`FBOS_OUT_W-1:0]  bank_state_q,
	output reg  [`FBOS_OUT_W-1:0]               rd_sel_q,
	output reg                                  rd_undef_q,
	output reg                                  in_setup_q,
	output reg  [`FBOS_ERR_W-1:0]               err_bits_q
);
	// ****************************************
	// Constants and helpers
	// ****************************************
	localparam PH_IDLE  = 1'b0;
	localparam PH_SETUP = 1'b1;

	function is_setup;
		input [`FBOS_CMD_W-1:0] c;
		begin
			is_setup = (c == `FBOS_CMD_PROG_SU) || (c == `FBOS_CMD_ERASE_SU) ||
				(c == `FBOS_CMD_FP_SU) || (c == `FBOS_CMD_QFP_SU);
		end
	endfunction

	// Picks one bank's output state out of a packed bank vector
	function [`FBOS_OUT_W-1:0] bank_field;
		input [`FBOS_NBANKS*`FBOS_OUT_W-1:0] vec;
		input [`FBOS_BANK_W-1:0]             idx;
		begin
			bank_field = vec[idx*`FBOS_OUT_W +: `FBOS_OUT_W];
		end
	endfunction

	// True when a command bank address names bank n
	function bank_hit;
		input [`FBOS_BANK_W-1:0] b;
		input integer            n;
		begin
			bank_hit = (b == n[`FBOS_BANK_W-1:0]);
		end
	endfunction

	// ****************************************
	// Pin synchronisers
	// ****************************************
	reg busy_s1_q;
	reg busy_q;
	reg susp_s1_q;
	reg susp_q;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_s1_q <= 1'b0;
			busy_q    <= 1'b0;
			susp_s1_q <= 1'b0;
			susp_q    <= 1'b0;
		end else begin
			busy_s1_q <= pe_busy;
			busy_q    <= busy_s1_q;
			susp_s1_q <= pe_suspended;
			susp_q    <= susp_s1_q;
		end
	end

	// ****************************************
	// Interface phase
	// ****************************************
	reg                     phase_q;
	reg                     phase_d;
	reg                     ignore_q;
	reg                     ignore_d;
	reg                     load_en;
	reg [`FBOS_OUT_W-1:0]   load_val;
	reg                     clr_ok;

	always @* begin
		phase_d  = phase_q;
		ignore_d = ignore_q;
		load_en  = 1'b0;
		load_val = `FBOS_OUT_ARRAY;
		clr_ok   = 1'b0;
		if (cmd_valid) begin
			case (phase_q)
				PH_IDLE: begin
					if (is_setup(cmd_code)) begin
						if (busy_q) begin
							ignore_d = 1'b1;
						end else begin
							phase_d  = PH_SETUP;
							load_en  = 1'b1;
							load_val = `FBOS_OUT_STATUS;
						end
						phase_d = PH_SETUP;
					end else begin
						case (cmd_code)
							`FBOS_CMD_RD_ARRAY: begin
								load_en  = 1'b1;
								load_val = `FBOS_OUT_ARRAY;
							end
							`FBOS_CMD_RD_STATUS: begin
								load_en  = 1'b1;
								load_val = `FBOS_OUT_STATUS;
							end
							`FBOS_CMD_RD_SIG: begin
								load_en  = 1'b1;
								load_val = `FBOS_OUT_SIG;
							end
							`FBOS_CMD_RD_QUERY: begin
								load_en  = 1'b1;
								load_val = `FBOS_OUT_QUERY;
							end
							`FBOS_CMD_CLR_STAT: begin
								clr_ok = !busy_q && !susp_q;
							end
							default: begin
								load_en = 1'b0;
							end
						endcase
					end
				end
				PH_SETUP: begin
					// Second cycle: ignored too if first was ignored
					phase_d  = PH_IDLE;
					ignore_d = 1'b0;
					load_en  = !ignore_q;
					load_val = `FBOS_OUT_STATUS;
				end
				default: begin
					phase_d  = PH_IDLE;
					ignore_d = 1'b0;
				end
			endcase
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_q    <= PH_IDLE;
			ignore_q   <= 1'b0;
			in_setup_q <= 1'b0;
		end else begin
			phase_q    <= phase_d;
			ignore_q   <= ignore_d;
			in_setup_q <= phase_d & ~ignore_d;
		end
	end

	// ****************************************
	// Bank state array
	// ****************************************
	wire [`FBOS_NBANKS*`FBOS_OUT_W-1:0] st_w;
	genvar gi;
	generate
		for (gi = 0; gi < `FBOS_NBANKS; gi = gi + 1) begin : g_bank
			fbos_bank_state u_bank (
				.clk     (clk),
				.rst_n   (rst_n),
				.load    (load_en && bank_hit(cmd_bank, gi)),
				.value   (load_val),
				.state_q (st_w[gi*`FBOS_OUT_W +: `FBOS_OUT_W])
			);
		end
	endgenerate

	// ****************************************
	// Outputs
	// ****************************************
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bank_state_q <= {`FBOS_NBANKS*`FBOS_OUT_W{1'b0}};
		end else begin
			bank_state_q <= st_w;
		end
	end

	// ****************************************
	// Read path
	// ****************************************
	// Output state of the bank being read, from the live bank registers
	wire [`FBOS_OUT_W-1:0] rd_field;
	assign rd_field = bank_field(st_w, rd_bank);

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_sel_q   <= `FBOS_OUT_ARRAY;
			rd_undef_q <= 1'b0;
		end else begin
			rd_sel_q   <= rd_field;
			rd_undef_q <= busy_q && (rd_field == `FBOS_OUT_ARRAY);
		end
	end

	// ****************************************
	// Status error bits
	// ****************************************
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			err_bits_q <= `FBOS_ERR_RESET;
		end else begin
			if (err_set) begin
				err_bits_q <= err_bits_q | err_in;
			end else if (clr_ok) begin
				err_bits_q <= `FBOS_ERR_RESET;
			end
		end
	end
endmodule // fbos_select

// ---- fbos_host.sv ----
/* Host model: writes classified command words to the selector.
   Assumes it shares clk with the selector and is driven by tasks. */
`include "fbos_map.vh"
module fbos_host (
	input  wire                     clk,
	output logic                    cmd_valid,
	output logic [`FBOS_CMD_W-1:0]  cmd_code,
	output logic [`FBOS_BANK_W-1:0] cmd_bank
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		cmd_valid = 1'h0;
		cmd_code = 4'h0;
		cmd_bank = 3'h0;
	end
	// One word, then the released lines carry an inverted pattern
	task send(input logic [3:0] c, input logic [2:0] b);
		@(posedge clk);
		#1 cmd_valid = 1'h1;
		cmd_code = c;
		cmd_bank = b;
		@(posedge clk);
		#1 cmd_valid = 1'h0;
		cmd_code = ~c;
		cmd_bank = ~b;
	endtask
endmodule // fbos_host

// ---- fbos_select_checker.sv ----
/* Assertions on the output state selector ports.
   Assumes it is bound to fbos_select; reset is async active low. */
`include "fbos_map.vh"
module fbos_select_checker (
	input wire                                clk,
	input wire                                rst_n,
	input wire                                cmd_valid,
	input wire [`FBOS_CMD_W-1:0]              cmd_code,
	input wire [`FBOS_BANK_W-1:0]             cmd_bank,
	input wire                                pe_busy,
	input wire                                pe_suspended,
	input wire                                err_set,
	input wire [`FBOS_NBANKS*`FBOS_OUT_W-1:0] bank_state_q,
	input wire                                in_setup_q,
	input wire [`FBOS_ERR_W-1:0]              err_bits_q
);
	reg  [2:0] b1_q;
	reg  [2:0] b2_q;
	reg        su_q;
	wire       su = cmd_code >= `FBOS_CMD_PROG_SU && cmd_code <= `FBOS_CMD_QFP_SU;
	wire       nx = cmd_valid && !su_q;
	wire [1:0] fld = bank_state_q[b2_q*2 +: 2];
	// Bank of two cycles ago; whether the last word opened a pair
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			b1_q <= 3'h0;
			b2_q <= 3'h0;
			su_q <= 1'h0;
		end else begin
			b1_q <= cmd_bank;
			b2_q <= b1_q;
			if (cmd_valid) su_q <= su;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence idle3; (!pe_busy && !pe_suspended)[*3]; endsequence
	sequence busy3; pe_busy[*3]; endsequence
	a_reset_array: assert property ($rose(rst_n) |-> bank_state_q == 16'h0000)
		else $error("bank not in array state after reset");
	a_rd_array: assert property (nx && cmd_code == `FBOS_CMD_RD_ARRAY |-> ##2 fld == 2'h0)
		else $error("read array did not select array");
	a_setup_status: assert property (idle3 ##0 (nx && su) |-> ##2 fld == 2'h1)
		else $error("setup did not select status");
	a_read_sig: assert property (nx && cmd_code == `FBOS_CMD_RD_SIG |-> ##2 fld == 2'h2)
		else $error("signature read not selected");
	a_second_status: assert property (cmd_valid && su_q && in_setup_q |-> ##2 fld == 2'h1)
		else $error("second word left status");
	a_keep_output: assert property (nx && cmd_code inside {`FBOS_CMD_CONFIRM, `FBOS_CMD_SUSPEND,
		`FBOS_CMD_CLR_STAT, `FBOS_CMD_OTHER} |-> ##2 $stable(bank_state_q))
		else $error("output changed by neutral command");
	a_hold_state: assert property (!cmd_valid |-> ##2 $stable(bank_state_q))
		else $error("output changed without command");
	a_busy_ignore: assert property (busy3 ##0 (nx && su) |=> !in_setup_q)
		else $error("setup accepted while busy");
	a_clear_err: assert property (idle3 ##0 (nx && cmd_code == `FBOS_CMD_CLR_STAT && !err_set)
		|-> ##[1:2] err_bits_q == 5'h00)
		else $error("error bits not cleared");
	a_busy_err: assert property (busy3 ##0 (cmd_valid && cmd_code == `FBOS_CMD_CLR_STAT)
		|=> $stable(err_bits_q)[*2])
		else $error("error bits cleared while busy");
endmodule // fbos_select_checker
bind fbos_select fbos_select_checker fbos_select_checker_inst (.clk(clk), .rst_n(rst_n),
	.cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_bank(cmd_bank), .pe_busy(pe_busy),
	.pe_suspended(pe_suspended), .err_set(err_set), .bank_state_q(bank_state_q),
	.in_setup_q(in_setup_q), .err_bits_q(err_bits_q));

// ---- testbench.sv ----
/* Self-checking bench for the output state selector.
   Assumes the host model and the checker are compiled first. */
`include "fbos_map.vh"
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	logic       clk, rst_n, pe_busy, pe_suspended, err_set;
	logic [4:0] err_in;
	logic [2:0] rd_bank;
	wire        cmd_valid, rd_undef, in_setup;
	wire  [3:0] cmd_code;
	wire  [2:0] cmd_bank;
	wire [15:0] bs;
	wire  [1:0] rd_sel;
	wire  [4:0] err_bits;
	int         fail_count, num_checks;
	logic [3:0] cs [4] = '{`FBOS_CMD_RD_SIG, `FBOS_CMD_RD_QUERY, `FBOS_CMD_RD_STATUS, 4'h0};
	logic [3:0] ks [4] = '{`FBOS_CMD_CONFIRM, `FBOS_CMD_SUSPEND, `FBOS_CMD_CLR_STAT, 4'hF};
	logic [1:0] es [4] = '{`FBOS_OUT_SIG, `FBOS_OUT_QUERY, `FBOS_OUT_STATUS, `FBOS_OUT_ARRAY};
	fbos_host fbos_host_inst (.clk(clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
		.cmd_bank(cmd_bank));
	fbos_select fbos_select_inst (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
		.cmd_code(cmd_code), .cmd_bank(cmd_bank), .pe_busy(pe_busy),
		.pe_suspended(pe_suspended), .err_set(err_set), .err_in(err_in), .rd_bank(rd_bank),
		.bank_state_q(bs), .rd_sel_q(rd_sel), .rd_undef_q(rd_undef), .in_setup_q(in_setup),
		.err_bits_q(err_bits));
	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end
	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	function logic [1:0] fld(input logic [2:0] b);
		return bs[b*2 +: 2];
	endfunction
	task end_sim;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task t_select;
		rd_bank = 3'h5;
		for (int i = 0; i < 4; i++) begin
			fbos_host_inst.send(cs[i], 3'h5);
			wt(3);
			chk("bank5", es[i], fld(3'h5));
			chk("bank4", `FBOS_OUT_ARRAY, fld(3'h4));
			chk("rd_sel", es[i], rd_sel);
			chk("rd_undef", 1'h0, rd_undef);
		end
		$display("test select done");
	endtask
	task t_keep;
		fbos_host_inst.send(`FBOS_CMD_RD_SIG, 3'h2);
		for (int i = 0; i < 4; i++) begin
			fbos_host_inst.send(ks[i], 3'h2);
			wt(20);
			chk("bank2", 2'h2, fld(3'h2));
		end
		$display("test keep done");
	endtask
	task t_setup;
		for (int i = 1; i < 5; i++) begin
			fbos_host_inst.send(4'(i), 3'h1);
			chk("in_setup", 1'h1, in_setup);
			wt(2);
			chk("bank1", 2'h1, fld(3'h1));
			fbos_host_inst.send(`FBOS_CMD_RD_SIG, 3'h1);
			wt(3);
			chk("bank1 pair", 2'h1, fld(3'h1));
			chk("in_setup", 1'h0, in_setup);
			fbos_host_inst.send(4'h0, 3'h1);
		end
		$display("test setup done");
	endtask
	task t_busy;
		pe_busy = 1'h1;
		err_set = 1'h1;
		err_in = 5'h15;
		wt(1);
		err_set = 1'h0;
		wt(4);
		fbos_host_inst.send(`FBOS_CMD_ERASE_SU, 3'h3);
		chk("in_setup", 1'h0, in_setup);
		fbos_host_inst.send(`FBOS_CMD_RD_QUERY, 3'h3);
		rd_bank = 3'h3;
		wt(3);
		chk("bank3", 2'h0, fld(3'h3));
		chk("rd_undef", 1'h1, rd_undef);
		for (int i = 0; i < 3; i++) begin
			fbos_host_inst.send(`FBOS_CMD_CLR_STAT, 3'h0);
			wt(3);
			chk("errs", i == 2 ? 5'h00 : 5'h15, err_bits);
			pe_busy = 1'h0;
			pe_suspended = (i == 0);
			wt(4);
		end
		$display("test busy done");
	endtask
	initial begin
		{rst_n, pe_busy, pe_suspended, err_set, err_in, rd_bank} = 12'h000;
		repeat (20) @(posedge clk);
		#1 rst_n = 1'h1;
		chk("banks", 16'h0000, bs);
		t_select();
		t_keep();
		t_setup();
		t_busy();
		end_sim();
	end
	initial begin
		#20000;
		fail_count++;
		end_sim();
	end
endmodule // testbench
